// ---- hw/spmp_pkg.sv ----
// spmp_pkg: constants, types and helpers shared by both ends of the serial port.
// assumes a single 40 MHz system clock at each end; link pins are sampled, not clocked on.
// Contract
// - port works as bus master or slave
// - full duplex, one bit each way per clock
// - select is active low, high means idle
// - deselected slave ignores clock and data
// - slave drives its data output only when selected
// - slave decodes register read, write, transfer-start commands
// - four modes from clock polarity and phase
// - external master clock at most 2 MHz
// - generated master clock at most 4 MHz
package spmp_pkg;
   localparam int CLK_HZ          = 40_000_000;
   localparam int SLV_SCK_MAX_HZ  = 2_000_000;
   localparam int MST_SCK_MAX_HZ  = 4_000_000;
   // least half periods, rounded up to whole cycles
   localparam int MST_HALF_CYC    = (CLK_HZ + 2 * MST_SCK_MAX_HZ - 1) / (2 * MST_SCK_MAX_HZ);
   localparam int HOST_HALF_CYC   = (CLK_HZ + 2 * SLV_SCK_MAX_HZ - 1) / (2 * SLV_SCK_MAX_HZ);
   localparam int DIV_W           = 8;
   localparam int BYTE_W          = 8;
   localparam int BIT_W           = 3;
   localparam int EDGE_W          = 4;
   localparam int OP_W            = 2;
   localparam int ADDR_W          = 6;
   localparam int FIFO_DEPTH      = 8;
   localparam logic [BIT_W-1:0]  LAST_BIT  = 3'h7;
   localparam logic [EDGE_W-1:0] LAST_EDGE = 4'hF;
   localparam logic [BYTE_W-1:0] SLV_FILL  = 8'h00;
   localparam logic              PIN_IDLE  = 1'h1;
   localparam logic              CS_ACTIVE = 1'h0;

   typedef enum logic [1:0] {
      OP_READ  = 2'b00,
      OP_WRITE = 2'b01,
      OP_DMA   = 2'b10,
      OP_NOP   = 2'b11
   } spmp_op_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_RUN  = 2'b10,
      ST_TAIL = 2'b11
   } spmp_mst_type;

   // clock leaves its idle level
   function automatic logic spmpLead(input logic prev, input logic cur, input logic cpol);
      return (prev == cpol) && (cur != cpol);
   endfunction : spmpLead

   // clock returns to its idle level
   function automatic logic spmpTrail(input logic prev, input logic cur, input logic cpol);
      return (prev != cpol) && (cur == cpol);
   endfunction : spmpTrail

   // bit on the line for a given count of bits already sampled, msb first
   function automatic logic spmpOutBit(input logic [BYTE_W-1:0] b, input logic [BIT_W-1:0] cnt);
      return b[LAST_BIT - cnt];
   endfunction : spmpOutBit
endpackage : spmp_pkg

// ---- hw/spmp_if.sv ----
// spmp_if: the four shared link wires between the device end and the host end.
// assumes each driver gives an output and an active-low enable; undriven wires pull high.
`timescale 1ns/1ps
interface spmp_if;
   import spmp_pkg::*;
   logic devSckOut;
   logic devSckOe_b;
   logic devChipSelectLowOut;
   logic devChipSelectLowOe_b;
   logic devMosiOut;
   logic devMosiOe_b;
   logic devMisoOut;
   logic devMisoOe_b;
   logic hostSckOut;
   logic hostSckOe_b;
   logic hostChipSelectLowOut;
   logic hostChipSelectLowOe_b;
   logic hostMosiOut;
   logic hostMosiOe_b;
   logic sck;
   logic chipSelectLow;
   logic mosi;
   logic miso;

   assign sck = !devSckOe_b ? devSckOut : (!hostSckOe_b ? hostSckOut : PIN_IDLE);
   assign chipSelectLow = !devChipSelectLowOe_b ? devChipSelectLowOut :
                          (!hostChipSelectLowOe_b ? hostChipSelectLowOut : PIN_IDLE);
   assign mosi = !devMosiOe_b ? devMosiOut : (!hostMosiOe_b ? hostMosiOut : PIN_IDLE);
   assign miso = !devMisoOe_b ? devMisoOut : PIN_IDLE;

   modport dev (
      input  sck, chipSelectLow, mosi, miso,
      output devSckOut, devSckOe_b, devChipSelectLowOut, devChipSelectLowOe_b,
      output devMosiOut, devMosiOe_b, devMisoOut, devMisoOe_b
   );
   modport host (
      input  miso,
      output hostSckOut, hostSckOe_b, hostChipSelectLowOut, hostChipSelectLowOe_b,
      output hostMosiOut, hostMosiOe_b
   );
endinterface : spmp_if

// ---- hw/spmp_fifo.sv ----
// spmp_fifo: synchronous first-in first-out buffer with valid/ready on both sides.
// assumes both sides run on the same clock.
`timescale 1ns/1ps
module spmp_fifo
   import spmp_pkg::*;
#(
   parameter int WIDTH = BYTE_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output      logic             inReady,
   output      logic [WIDTH-1:0] outData,
   output      logic             outValid,
   input  wire logic             outReady
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wrPtr;
      logic [PTR_W-1:0]            rdPtr;
      logic [PTR_W:0]              count;
   } spmp_fifo_type;

   spmp_fifo_type s_r;
   spmp_fifo_type s_nxt;
   logic          doWr;
   logic          doRd;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
   endfunction : bump

   assign inReady  = (s_r.count != (PTR_W + 1)'(DEPTH));
   assign outValid = (s_r.count != '0);
   assign outData  = s_r.mem[s_r.rdPtr];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;

   always_comb begin
      s_nxt = s_r;
      if (doWr) begin
         s_nxt.mem[s_r.wrPtr] = inData;
         s_nxt.wrPtr          = bump(s_r.wrPtr);
      end
      if (doRd) begin
         s_nxt.rdPtr = bump(s_r.rdPtr);
      end
      if (doWr && !doRd) begin
         s_nxt.count = s_r.count + 1'b1;
      end else if (doRd && !doWr) begin
         s_nxt.count = s_r.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule : spmp_fifo

// ---- hw/spmp_port.sv ----
// spmp_port: device end, a serial port that is either link master or command-driven slave.
// assumes link pins are asynchronous to clock and that a master keeps at least 10 system
// cycles per clock half period (2 MHz against 40 MHz).
`timescale 1ns/1ps
module spmp_port
   import spmp_pkg::*;
#(
   parameter int HALF = MST_HALF_CYC
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              isMaster,
   input  wire logic              cpol,
   input  wire logic              cpha,
   input  wire logic [BYTE_W-1:0] txData,
   input  wire logic              txValid,
   output      logic              txReady,
   output      logic [BYTE_W-1:0] rxData,
   output      logic              rxValid,
   output      logic [ADDR_W-1:0] regAddr,
   output      logic [BYTE_W-1:0] regWrData,
   output      logic              regWr,
   input  wire logic [BYTE_W-1:0] regRdData,
   output      logic              dmaStart,
   output      logic [ADDR_W-1:0] dmaSel,
   output      logic              busy,
   spmp_if.dev                    pins
);
   typedef struct packed {
      logic [1:0]        sckS;
      logic [1:0]        csS;
      logic [1:0]        mosiS;
      logic [1:0]        misoS;
      logic              sckPrev;
      logic              csPrev;
      spmp_mst_type      st;
      logic [DIV_W-1:0]  div;
      logic [EDGE_W-1:0] edges;
      logic [BIT_W-1:0]  bitCnt;
      logic [BYTE_W-1:0] txByte;
      logic [BYTE_W-1:0] shiftIn;
      logic              sckLvl;
      logic              csLvl;
      logic              txBit;
      logic              cmdPhase;
      spmp_op_type       op;
      logic              loadRd;
      logic [BYTE_W-1:0] rxData;
      logic              rxValid;
      logic [ADDR_W-1:0] regAddr;
      logic [BYTE_W-1:0] regWrData;
      logic              regWr;
      logic              dmaStart;
   } spmp_port_type;

   localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(HALF - 1);

   spmp_port_type     s_r;
   spmp_port_type     s_nxt;
   logic [BYTE_W-1:0] fifoData;
   logic              fifoValid;
   logic              popFifo;

   // master bytes are buffered so a burst can run with select held low
   spmp_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) txFifo (
      .clock    (clock),
      .rst_b    (rst_b),
      .inData   (txData),
      .inValid  (txValid),
      .inReady  (txReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (popFifo)
   );

   always_comb begin
      logic              sampleEv;
      logic              selected;
      logic [BYTE_W-1:0] byteIn;
      logic              shiftEv;
      sampleEv = 1'b0;
      shiftEv  = 1'b0;
      selected = 1'b0;
      byteIn   = '0;
      popFifo  = 1'b0;
      s_nxt    = s_r;
      // only the second stage of each synchroniser is ever read
      s_nxt.sckS     = {s_r.sckS[0], pins.sck};
      s_nxt.csS      = {s_r.csS[0], pins.chipSelectLow};
      s_nxt.mosiS    = {s_r.mosiS[0], pins.mosi};
      s_nxt.misoS    = {s_r.misoS[0], pins.miso};
      s_nxt.sckPrev  = s_r.sckS[1];
      s_nxt.csPrev   = s_r.csS[1];
      s_nxt.rxValid  = 1'b0;
      s_nxt.regWr    = 1'b0;
      s_nxt.dmaStart = 1'b0;
      s_nxt.loadRd   = 1'b0;
      if (!isMaster) begin
         s_nxt.st     = ST_IDLE;
         s_nxt.sckLvl = cpol;
         s_nxt.csLvl  = PIN_IDLE;
         selected     = (s_r.csS[1] == CS_ACTIVE);
         if (s_r.loadRd) begin
            s_nxt.txByte = regRdData;
         end
         if (selected && (s_r.csPrev != CS_ACTIVE)) begin
            // a new frame always opens with a command byte
            s_nxt.bitCnt   = '0;
            s_nxt.cmdPhase = 1'b0;
            s_nxt.txByte   = SLV_FILL;
         end else if (selected) begin
            sampleEv = cpha ? spmpTrail(s_r.sckPrev, s_r.sckS[1], cpol)
                            : spmpLead(s_r.sckPrev, s_r.sckS[1], cpol);
         end
      end else begin
         s_nxt.cmdPhase = 1'b0;
         unique case (s_r.st)
            ST_IDLE: begin
               s_nxt.sckLvl = cpol;
               s_nxt.csLvl  = PIN_IDLE;
               if (fifoValid) begin
                  popFifo      = 1'b1;
                  s_nxt.txByte = fifoData;
                  s_nxt.bitCnt = '0;
                  s_nxt.edges  = '0;
                  s_nxt.csLvl  = CS_ACTIVE;
                  s_nxt.div    = DIV_LOAD;
                  s_nxt.st     = ST_LEAD;
                  shiftEv      = 1'b1;
               end
            end
            ST_LEAD: begin
               if (s_r.div == '0) begin
                  s_nxt.div = DIV_LOAD;
                  s_nxt.st  = ST_RUN;
               end else begin
                  s_nxt.div = s_r.div - 1'b1;
               end
            end
            ST_RUN: begin
               if (s_r.div == '0) begin
                  s_nxt.div    = DIV_LOAD;
                  s_nxt.sckLvl = !s_r.sckLvl;
                  s_nxt.edges  = s_r.edges + 1'b1;
                  // even edge counts are leading edges
                  sampleEv     = (s_r.edges[0] == cpha);
                  shiftEv      = (s_r.edges[0] != cpha);
                  if (s_r.edges == LAST_EDGE) begin
                     if (fifoValid) begin
                        popFifo      = 1'b1;
                        s_nxt.txByte = fifoData;
                     end else begin
                        s_nxt.st = ST_TAIL;
                     end
                  end
               end else begin
                  s_nxt.div = s_r.div - 1'b1;
               end
            end
            ST_TAIL: begin
               if (s_r.div == '0) begin
                  s_nxt.csLvl = PIN_IDLE;
                  s_nxt.st    = ST_IDLE;
               end else begin
                  s_nxt.div = s_r.div - 1'b1;
               end
            end
         endcase
      end
      if (sampleEv) begin
         byteIn        = {s_r.shiftIn[BYTE_W-2:0], isMaster ? s_r.misoS[1] : s_r.mosiS[1]};
         s_nxt.shiftIn = byteIn;
         s_nxt.bitCnt  = s_r.bitCnt + 1'b1;
         if (s_r.bitCnt == LAST_BIT) begin
            s_nxt.rxData  = byteIn;
            s_nxt.rxValid = 1'b1;
            if (!isMaster && !s_r.cmdPhase) begin
               s_nxt.op       = spmp_op_type'(byteIn[BYTE_W-1 -: OP_W]);
               s_nxt.regAddr  = byteIn[ADDR_W-1:0];
               s_nxt.cmdPhase = 1'b1;
               s_nxt.txByte   = SLV_FILL;
               s_nxt.loadRd   = (byteIn[BYTE_W-1 -: OP_W] == OP_READ);
               s_nxt.dmaStart = (byteIn[BYTE_W-1 -: OP_W] == OP_DMA);
            end else if (!isMaster) begin
               s_nxt.cmdPhase  = 1'b0;
               s_nxt.txByte    = SLV_FILL;
               s_nxt.regWrData = byteIn;
               s_nxt.regWr     = (s_r.op == OP_WRITE);
            end
         end
      end
      // as master the line only moves at frame start and on shift edges, never at the far end's sampling edge
      if (!isMaster || shiftEv) begin
         s_nxt.txBit = spmpOutBit(s_nxt.txByte, s_nxt.bitCnt);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_r        <= '0;
         s_r.sckS   <= {PIN_IDLE, PIN_IDLE};
         s_r.csS    <= {PIN_IDLE, PIN_IDLE};
         s_r.csPrev <= PIN_IDLE;
         s_r.csLvl  <= PIN_IDLE;
         s_r.op     <= OP_NOP;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rxData    = s_r.rxData;
   assign rxValid   = s_r.rxValid;
   assign regAddr   = s_r.regAddr;
   assign regWrData = s_r.regWrData;
   assign regWr     = s_r.regWr;
   assign dmaStart  = s_r.dmaStart;
   assign dmaSel    = s_r.regAddr;
   assign busy      = isMaster ? (s_r.st != ST_IDLE) : (s_r.csS[1] == CS_ACTIVE);

   assign pins.devSckOut           = s_r.sckLvl;
   assign pins.devSckOe_b          = !isMaster;
   assign pins.devChipSelectLowOut = s_r.csLvl;
   assign pins.devChipSelectLowOe_b = !isMaster;
   assign pins.devMosiOut          = s_r.txBit;
   assign pins.devMosiOe_b         = !isMaster;
   assign pins.devMisoOut          = s_r.txBit;
   // released the moment the synchronised select goes high
   assign pins.devMisoOe_b         = isMaster || (s_r.csS[1] != CS_ACTIVE);
endmodule : spmp_port

// ---- hw/spmp_host.sv ----
// spmp_host: far end, an external master that issues two-byte command frames.
// assumes the device end is in slave mode; the returned data byte is the second one received.
`timescale 1ns/1ps
module spmp_host
   import spmp_pkg::*;
#(
   parameter int HALF = HOST_HALF_CYC
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              hostActive,
   input  wire logic              cpol,
   input  wire logic              cpha,
   input  wire logic              cmdValid,
   output      logic              cmdReady,
   input  wire logic [OP_W-1:0]   cmdOp,
   input  wire logic [ADDR_W-1:0] cmdAddr,
   input  wire logic [BYTE_W-1:0] cmdData,
   output      logic              respValid,
   output      logic [BYTE_W-1:0] respData,
   spmp_if.host                   pins
);
   typedef struct packed {
      logic [1:0]        misoS;
      spmp_mst_type      st;
      logic [DIV_W-1:0]  div;
      logic [EDGE_W-1:0] edges;
      logic [BIT_W-1:0]  bitCnt;
      logic [BYTE_W-1:0] txByte;
      logic [BYTE_W-1:0] dataByte;
      logic [BYTE_W-1:0] shiftIn;
      logic              second;
      logic              sckLvl;
      logic              csLvl;
      logic              txBit;
      logic              respValid;
      logic [BYTE_W-1:0] respData;
   } spmp_host_type;

   // half period kept long enough for the slave's clock limit
   localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(HALF - 1);

   spmp_host_type s_r;
   spmp_host_type s_nxt;

   assign cmdReady = hostActive && (s_r.st == ST_IDLE);

   always_comb begin
      logic [BYTE_W-1:0] byteIn;
      logic              shiftEv;
      byteIn          = '0;
      shiftEv         = 1'b0;
      s_nxt           = s_r;
      s_nxt.misoS     = {s_r.misoS[0], pins.miso};
      s_nxt.respValid = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            s_nxt.sckLvl = cpol;
            s_nxt.csLvl  = PIN_IDLE;
            if (cmdValid && cmdReady) begin
               s_nxt.txByte   = {cmdOp, cmdAddr};
               s_nxt.dataByte = cmdData;
               s_nxt.second   = 1'b0;
               s_nxt.bitCnt   = '0;
               s_nxt.edges    = '0;
               s_nxt.csLvl    = CS_ACTIVE;
               s_nxt.div      = DIV_LOAD;
               s_nxt.st       = ST_LEAD;
               shiftEv        = 1'b1;
            end
         end
         ST_LEAD: begin
            if (s_r.div == '0) begin
               s_nxt.div = DIV_LOAD;
               s_nxt.st  = ST_RUN;
            end else begin
               s_nxt.div = s_r.div - 1'b1;
            end
         end
         ST_RUN: begin
            if (s_r.div == '0) begin
               s_nxt.div    = DIV_LOAD;
               s_nxt.sckLvl = !s_r.sckLvl;
               s_nxt.edges  = s_r.edges + 1'b1;
               if (s_r.edges[0] == cpha) begin
                  byteIn        = {s_r.shiftIn[BYTE_W-2:0], s_r.misoS[1]};
                  s_nxt.shiftIn = byteIn;
                  s_nxt.bitCnt  = s_r.bitCnt + 1'b1;
                  if ((s_r.bitCnt == LAST_BIT) && s_r.second) begin
                     s_nxt.respData  = byteIn;
                     s_nxt.respValid = 1'b1;
                  end
               end else begin
                  // data moves on the opposite edge so it never changes under the sampler
                  shiftEv = 1'b1;
               end
               if (s_r.edges == LAST_EDGE) begin
                  if (!s_r.second) begin
                     s_nxt.second = 1'b1;
                     s_nxt.txByte = s_r.dataByte;
                  end else begin
                     s_nxt.st = ST_TAIL;
                  end
               end
            end else begin
               s_nxt.div = s_r.div - 1'b1;
            end
         end
         ST_TAIL: begin
            if (s_r.div == '0) begin
               s_nxt.csLvl = PIN_IDLE;
               s_nxt.st    = ST_IDLE;
            end else begin
               s_nxt.div = s_r.div - 1'b1;
            end
         end
      endcase
      if (shiftEv) begin
         s_nxt.txBit = spmpOutBit(s_nxt.txByte, s_nxt.bitCnt);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_r       <= '0;
         s_r.misoS <= {PIN_IDLE, PIN_IDLE};
         s_r.csLvl <= PIN_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign respValid                  = s_r.respValid;
   assign respData                   = s_r.respData;
   assign pins.hostSckOut            = s_r.sckLvl;
   assign pins.hostSckOe_b           = !hostActive;
   assign pins.hostChipSelectLowOut  = s_r.csLvl;
   assign pins.hostChipSelectLowOe_b = !hostActive;
   assign pins.hostMosiOut           = s_r.txBit;
   assign pins.hostMosiOe_b          = !hostActive;
endmodule : spmp_host

// ---- test/spmp_link_asserts.sv ----
// spmp_link_asserts: wire-level checks on the shared link between both ends.
// assumes instantiation beside the link interface, sampled on the system clock.
`timescale 1ns/1ps
module spmp_link_asserts (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic isMaster,
   input wire logic cpol,
   input wire logic sck,
   input wire logic chipSelectLow,
   input wire logic devMisoOe_b
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_miso_release: assert property (chipSelectLow[*8] ##0 !isMaster |-> devMisoOe_b)
      else $error("miso driven while deselected");
   a_miso_drive: assert property ((!chipSelectLow)[*8] ##0 !isMaster |-> !devMisoOe_b)
      else $error("miso not driven while selected");
   // mode bits may only move while idle, so settle them before judging the idle level
   a_sck_idle: assert property (chipSelectLow[*8] ##0 (cpol == $past(cpol, 8))
      ##0 (isMaster == $past(isMaster, 8)) |-> sck == cpol)
      else $error("clock not at idle level");
   a_edge_framed: assert property ($changed(sck) && cpol == $past(cpol, 3)
      && isMaster == $past(isMaster, 3) |-> !chipSelectLow)
      else $error("clock edge outside frame");
   a_lead_gap: assert property ($fell(chipSelectLow) |=> $stable(sck)[*4])
      else $error("clock edge too soon after select");
   a_mst_rate: assert property ($changed(sck) && isMaster && !chipSelectLow
      |=> $stable(sck)[*4])
      else $error("master clock too fast");
   a_host_rate: assert property ($changed(sck) && !isMaster && !chipSelectLow
      |=> $stable(sck)[*8])
      else $error("host clock too fast");
   a_frame_whole: assert property ($fell(chipSelectLow) |-> (!chipSelectLow)[*8])
      else $error("frame cut short");
endmodule : spmp_link_asserts

// ---- test/spi_master_slave_port_tb.sv ----
// spi_master_slave_port_tb: device end faces the host end across the link interface.
// assumes the command format of the package; read data is a fixed function of address.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module spi_master_slave_port_tb;
   import spmp_pkg::*;
   logic              clock      = 1'b0;
   logic              rst_b      = 1'b0;
   logic              isMaster   = 1'b0;
   logic              hostActive = 1'b1;
   logic              cpol       = 1'b0;
   logic              cpha       = 1'b0;
   logic              txValid    = 1'b0;
   logic              cmdValid   = 1'b0;
   logic [BYTE_W-1:0] txData     = 8'h00;
   logic [BYTE_W-1:0] cmdData    = 8'h00;
   logic [ADDR_W-1:0] cmdAddr    = 6'h00;
   logic [OP_W-1:0]   cmdOp      = 2'h3;
   logic [BYTE_W-1:0] rxData, regWrData, regRdData, respData, rxLast;
   logic [ADDR_W-1:0] regAddr, dmaSel;
   logic              txReady, rxValid, regWr, dmaStart, busy, cmdReady, respValid;
   logic              sckQ, csQ;
   logic [15:0]       capBits;
   int                error_cnt, check_count, wrCnt, dmaCnt, rxCnt, csRise;

   spmp_if u_spmp_if ();
   wire linkSck  = u_spmp_if.sck;
   wire linkCs   = u_spmp_if.chipSelectLow;
   wire linkMosi = u_spmp_if.mosi;
   assign regRdData = {2'h0, regAddr} ^ 8'h5A;

   always #12.5 clock = ~clock;

   spmp_port u_spmp_port (.clock(clock), .rst_b(rst_b), .isMaster(isMaster), .cpol(cpol),
      .cpha(cpha), .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
      .rxValid(rxValid), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRdData(regRdData), .dmaStart(dmaStart), .dmaSel(dmaSel), .busy(busy),
      .pins(u_spmp_if));
   spmp_host u_spmp_host (.clock(clock), .rst_b(rst_b), .hostActive(hostActive),
      .cpol(cpol), .cpha(cpha), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .respValid(respValid), .respData(respData),
      .pins(u_spmp_if));
   spmp_link_asserts u_spmp_link_asserts (.clock(clock), .rst_b(rst_b), .isMaster(isMaster),
      .cpol(cpol), .sck(linkSck), .chipSelectLow(linkCs),
      .devMisoOe_b(u_spmp_if.devMisoOe_b));

   // independent wire monitor: mosi taken on the sampling edge that cpol and cpha select
   always @(posedge clock) begin
      sckQ <= linkSck;
      csQ <= linkCs;
      if (linkCs && !csQ) csRise++;
      if (!linkCs && linkSck !== sckQ && ((linkSck != cpol) ^ cpha))
         capBits <= {capBits[14:0], linkMosi};
      if (regWr) wrCnt++;
      if (dmaStart) dmaCnt++;
      if (rxValid) begin
         rxCnt++;
         rxLast <= rxData;
      end
   end

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic hostCmd(input int o, input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
      int n, w0, m0, r0;
      logic [BYTE_W-1:0] exp;
      w0 = wrCnt;
      m0 = dmaCnt;
      r0 = rxCnt;
      exp = (o == 0) ? ({2'h0, a} ^ 8'h5A) : SLV_FILL;
      cmdOp = o[1:0];
      cmdAddr = a;
      cmdData = d;
      cmdValid = 1'b1;
      for (n = 0; n < 100 && !cmdReady; n++) tick();
      tick();
      cmdValid = 1'b0;
      for (n = 0; n < 1000 && !respValid; n++) tick();
      `CHK(respValid, 1'b1)
      `CHK(respData, exp)
      tick(12);
      `CHK(capBits, {o[1:0], a, d})
      `CHK(regAddr, a)
      `CHK(wrCnt - w0, (o == 1) ? 1 : 0)
      `CHK(dmaCnt - m0, (o == 2) ? 1 : 0)
      `CHK(rxCnt - r0, 2)
      `CHK(rxLast, d)
      if (o == 1) `CHK(regWrData, d)
      if (o == 2) `CHK(dmaSel, a)
   endtask : hostCmd

   initial begin
      int n, r0, c0;
      tick(6);
      rst_b = 1'b1;
      tick(2);
      for (int m = 0; m < 4; m++) begin
         {cpol, cpha} = m[1:0];
         tick(20);
         for (int o = 0; o < 4; o++) hostCmd(o, 6'(m * 16 + o * 3 + 1), 8'hA5 ^ 8'(m * 17 + o));
      end
      {cpol, cpha} = 2'h2;
      // slave mode parks outgoing bytes, so the ninth push must be refused
      txValid = 1'b1;
      for (int i = 0; i < 8; i++) begin
         txData = 8'hC0 + 8'(i);
         tick();
      end
      `CHK(txReady, 1'b0)
      txData = 8'hEE;
      tick();
      txValid = 1'b0;
      r0 = rxCnt;
      c0 = csRise;
      hostActive = 1'b0;
      isMaster = 1'b1;
      for (n = 0; n < 3000 && rxCnt - r0 < 8; n++) tick();
      tick(20);
      `CHK(rxCnt - r0, 8)
      `CHK(rxLast, 8'hFF)
      `CHK(capBits, 16'hC6C7)
      `CHK(csRise - c0, 1)
      `CHK(busy, 1'b0)
      `CHK(txReady, 1'b1)
      end_of_test();
   end

   initial begin
      #500000;
      error_cnt++;
      end_of_test();
   end
endmodule : spi_master_slave_port_tb
